// File: hdl/fpfc_core.v
`timescale 1ns/1ps
`default_nettype none
`include "fpfc_regs.vh"

// Summary of operation
// - supply undervoltage blocks turn-on until shunt level
// - standard or increased peak current cap
// - cap selection latched once before switching
// - supply overcurrent latches or restarts after off-time
// - hysteretic thermal disables until temperature falls
// - latching thermal held until supply/line reset
// - limit ramps down with time since turn-off
// - request starts cycle immediately at ramp value
// - limit up to 100 percent, floor 30 percent
// - jitter modulates limit between 100 and 95
// - sustained fast requests trigger auto-restart
// - request silence triggers auto-restart
// - first off-time short, later full
// - line reset clears auto-restart at once
// - latched faults clear on supply/line reset
// - two early cap hits skip 25 us
// - cap hit within 200 ns forces 30 us off
// - repeat short after 30 us gives 200 ms
// - wait restart on-time, listen for two requests
// - line fault restart waits for line in range
module fpfc_core #(
    parameter integer AR_OFF_CYC = 1500 * `FPFC_MS_CYC,
    parameter integer AR_OFF_SH_CYC = 100 * `FPFC_MS_CYC,
    parameter integer SILENCE_CYC = 800 * `FPFC_MS_CYC,
    parameter integer OVL_CYC = `FPFC_OVL_MS * `FPFC_MS_CYC,
    parameter integer LISTEN_CYC = `FPFC_OVL_MS * `FPFC_MS_CYC,
    parameter integer SRS_LONG_CYC = `FPFC_SRS_LONG_MS * `FPFC_MS_CYC,
    parameter integer RAMP_CYC = 4000,
    parameter integer JIT_HALF_CYC = 10000,
    parameter integer LISTEN_TOL_CYC = 100
) (
    input wire clock_i,
    input wire arst_n_i,
    input wire cycle_request_i,
    input wire cap_reached_i,
    input wire supply_below_uv_i,
    input wire supply_at_shunt_i,
    input wire supply_below_reset_i,
    input wire supply_overcurrent_i,
    input wire supply_cap_large_i,
    input wire supply_charged_i,
    input wire thermal_over_i,
    input wire thermal_cooled_i,
    input wire thermal_latch_mode_i,
    input wire fault_latch_mode_i,
    input wire line_under_i,
    input wire line_over_i,
    output reg switch_on_o,
    output reg [6:0] peak_current_cap_pct_o,
    output reg cap_increased_o,
    output reg auto_restart_state_o,
    output reg latched_off_o,
    output reg switching_enabled_o
);
    // ---------------------------------------------
    // derived counts
    // ---------------------------------------------
    localparam integer EARLY_CYC = (`FPFC_EARLY_NS + `FPFC_CLK_NS - 1) / `FPFC_CLK_NS;
    localparam integer SHORT_CYC = (`FPFC_SHORT_NS + `FPFC_CLK_NS - 1) / `FPFC_CLK_NS;
    localparam integer SRS_OFF_CYC = `FPFC_SRS_OFF_US * `FPFC_US_CYC;
    localparam integer SKIP_CYC = `FPFC_SKIP_US * `FPFC_US_CYC;
    localparam integer LSPACE_CYC = `FPFC_LISTEN_US * `FPFC_US_CYC;
    localparam integer OVL_PER_CYC = `FPFC_OVL_PERIOD_NS / `FPFC_CLK_NS;
    localparam [6:0] RAMP_SPAN = `FPFC_PCT_FULL - `FPFC_PCT_MIN;

    reg [2:0] state;
    reg [31:0] tmr;
    reg [31:0] since_off;
    reg [31:0] since_req;
    reg [31:0] ovl_cnt;
    reg [31:0] on_cnt;
    reg [31:0] jit_cnt;
    reg jit_low;
    reg cap_taken;
    reg uv_block;
    reg thermal_block;
    reg ar_short_used;
    reg early_prev;
    reg srs_after;
    reg line_wait;
    reg listen_seen;
    reg [31:0] listen_gap;
    reg [31:0] ramp_drop;
    reg [6:0] ramp_pct;

    wire line_reset = supply_below_reset_i | line_under_i;
    wire inhibit = uv_block | thermal_block | line_under_i | line_over_i | ~cap_taken;

    // ---------------------------------------------
    // current limit ramp and jitter
    // ---------------------------------------------
    // limit falls linearly with idle time, floor at minimum
    always @* begin
        ramp_drop = (since_off * RAMP_SPAN) / RAMP_CYC;
        if (ramp_drop >= RAMP_SPAN)
            ramp_pct = `FPFC_PCT_MIN;
        else
            ramp_pct = `FPFC_PCT_FULL - ramp_drop[6:0];
        if (jit_low && ramp_pct > `FPFC_PCT_MIN + `FPFC_PCT_JIT)
            ramp_pct = ramp_pct - `FPFC_PCT_JIT;
    end

    // jitter square wave: limit between 100 and 95 percent scale
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            jit_cnt <= 32'h0;
            jit_low <= 1'b0;
        end else if (jit_cnt >= JIT_HALF_CYC - 1) begin
            jit_cnt <= 32'h0;
            jit_low <= ~jit_low;
        end else begin
            jit_cnt <= jit_cnt + 32'h1;
        end
    end

    // ---------------------------------------------
    // supply, thermal and cap selection
    // ---------------------------------------------
    // strap caught by clock after supply charges, never again
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cap_taken <= 1'b0;
            cap_increased_o <= 1'b0;
            uv_block <= 1'b1;
            thermal_block <= 1'b0;
        end else begin
            if (!cap_taken && supply_charged_i) begin
                cap_taken <= 1'b1;
                cap_increased_o <= supply_cap_large_i;
            end
            if (supply_below_uv_i)
                uv_block <= 1'b1;
            else if (supply_at_shunt_i)
                uv_block <= 1'b0;
            if (thermal_over_i)
                thermal_block <= 1'b1;
            else if (thermal_latch_mode_i ? line_reset : thermal_cooled_i)
                thermal_block <= 1'b0;
        end
    end

    // ---------------------------------------------
    // switching and fault sequencer
    // ---------------------------------------------
    // one process owns state so a fault can never race a request
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= `FPFC_ST_RUN;
            tmr <= 32'h0;
            since_off <= 32'h0;
            since_req <= 32'h0;
            ovl_cnt <= 32'h0;
            on_cnt <= 32'h0;
            switch_on_o <= 1'b0;
            peak_current_cap_pct_o <= `FPFC_PCT_FULL;
            auto_restart_state_o <= 1'b0;
            latched_off_o <= 1'b0;
            switching_enabled_o <= 1'b0;
            ar_short_used <= 1'b0;
            early_prev <= 1'b0;
            srs_after <= 1'b0;
            line_wait <= 1'b0;
            listen_seen <= 1'b0;
            listen_gap <= 32'h0;
        end else begin
            if (since_off != 32'hFFFFFFFF)
                since_off <= since_off + 32'h1;
            if (since_req != 32'hFFFFFFFF)
                since_req <= since_req + 32'h1;
            if (tmr != 32'h0)
                tmr <= tmr - 32'h1;
            switching_enabled_o <= (state == `FPFC_ST_RUN) && !inhibit;
            auto_restart_state_o <= (state == `FPFC_ST_AR_OFF) || (state == `FPFC_ST_LISTEN);
            latched_off_o <= (state == `FPFC_ST_LATCH);
            if (line_under_i || line_over_i)
                line_wait <= 1'b1;
            // overload: requests faster than the rate, sustained
            if (cycle_request_i) begin
                since_req <= 32'h0;
                if (since_req < OVL_PER_CYC)
                    ovl_cnt <= ovl_cnt + 32'h1;
                else
                    ovl_cnt <= 32'h0;
            end else if (since_req >= OVL_PER_CYC) begin
                ovl_cnt <= 32'h0;
            end else begin
                ovl_cnt <= ovl_cnt + 32'h1;
            end
            case (state)
                `FPFC_ST_RUN: begin
                    if (switch_on_o) begin
                        on_cnt <= on_cnt + 32'h1;
                        if (cap_reached_i || inhibit) begin
                            switch_on_o <= 1'b0;
                            since_off <= 32'h0;
                            on_cnt <= 32'h0;
                            early_prev <= cap_reached_i && (on_cnt < EARLY_CYC);
                            srs_after <= 1'b0;
                            if (cap_reached_i && on_cnt < SHORT_CYC) begin
                                state <= `FPFC_ST_SRS_OFF;
                                tmr <= srs_after ? SRS_LONG_CYC : SRS_OFF_CYC;
                                srs_after <= 1'b1;
                            end else if (cap_reached_i && on_cnt < EARLY_CYC && early_prev) begin
                                state <= `FPFC_ST_SKIP;
                                tmr <= SKIP_CYC;
                                early_prev <= 1'b0;
                            end
                        end
                    end else if (supply_overcurrent_i) begin
                        state <= fault_latch_mode_i ? `FPFC_ST_LATCH : `FPFC_ST_AR_OFF;
                        tmr <= ar_short_used ? AR_OFF_CYC : AR_OFF_SH_CYC;
                        ar_short_used <= 1'b1;
                    end else if (ovl_cnt >= OVL_CYC || since_req >= SILENCE_CYC) begin
                        state <= `FPFC_ST_AR_OFF;
                        tmr <= ar_short_used ? AR_OFF_CYC : AR_OFF_SH_CYC;
                        ar_short_used <= 1'b1;
                        ovl_cnt <= 32'h0;
                    end else if (cycle_request_i && !inhibit) begin
                        switch_on_o <= 1'b1;
                        peak_current_cap_pct_o <= ramp_pct;
                        on_cnt <= 32'h0;
                    end
                end
                `FPFC_ST_SRS_OFF, `FPFC_ST_SKIP: begin
                    if (tmr == 32'h0) begin
                        state <= `FPFC_ST_RUN;
                        since_req <= 32'h0;
                    end
                end
                `FPFC_ST_AR_OFF: begin
                    if (line_reset) begin
                        state <= `FPFC_ST_RUN;
                        ar_short_used <= 1'b0;
                        since_req <= 32'h0;
                    end else if (tmr == 32'h0 && !(line_wait && (line_under_i || line_over_i))) begin
                        state <= `FPFC_ST_LISTEN;
                        line_wait <= 1'b0;
                        tmr <= LISTEN_CYC;
                        listen_seen <= 1'b0;
                    end
                end
                `FPFC_ST_LISTEN: begin
                    if (cycle_request_i) begin
                        listen_seen <= 1'b1;
                        listen_gap <= 32'h0;
                    end else begin
                        listen_gap <= listen_gap + 32'h1;
                    end
                    if (line_reset) begin
                        state <= `FPFC_ST_RUN;
                        ar_short_used <= 1'b0;
                        since_req <= 32'h0;
                    end else if ((cycle_request_i && listen_seen && listen_gap + LISTEN_TOL_CYC >= LSPACE_CYC &&
                                  listen_gap <= LSPACE_CYC + LISTEN_TOL_CYC) || tmr == 32'h0) begin
                        state <= `FPFC_ST_RUN;
                        since_req <= 32'h0;
                        ovl_cnt <= 32'h0;
                    end
                end
                `FPFC_ST_LATCH: begin
                    if (line_reset) begin
                        state <= `FPFC_ST_RUN;
                        ar_short_used <= 1'b0;
                        since_req <= 32'h0;
                    end
                end
                default: state <= `FPFC_ST_RUN;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: include/fpfc_regs.vh
`ifndef FPFC_REGS_VH
`define FPFC_REGS_VH
// ---------------------------------------------
// clock and timing
// ---------------------------------------------
`define FPFC_CLK_HZ 20000000
`define FPFC_CLK_NS 50
`define FPFC_US_CYC 20
`define FPFC_MS_CYC 20000
// early window 500 ns, short detect 200 ns (ns, rounded up)
`define FPFC_EARLY_NS 500
`define FPFC_SHORT_NS 200
// short-detect off-time 30 us, skip 25 us, listen spacing 30 us
`define FPFC_SRS_OFF_US 30
`define FPFC_SKIP_US 25
`define FPFC_LISTEN_US 30
// long rectifier-short off-time 200 ms, overload window 82 ms
`define FPFC_SRS_LONG_MS 200
`define FPFC_OVL_MS 82
// overload rate 110 kHz: request period limit in ns
`define FPFC_OVL_PERIOD_NS 9090
// ramp: percent scale
`define FPFC_PCT_FULL 7'h64
`define FPFC_PCT_MIN 7'h1E
`define FPFC_PCT_JIT 7'h05
// fault sequencer states
`define FPFC_ST_RUN 3'h0
`define FPFC_ST_AR_OFF 3'h1
`define FPFC_ST_LISTEN 3'h2
`define FPFC_ST_LATCH 3'h3
`define FPFC_ST_SRS_OFF 3'h4
`define FPFC_ST_SKIP 3'h5
`endif

// File: tb/fpfc_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// port checker
// ------------------------------
module fpfc_core_sva (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic cycle_request_i,
    input wire logic cap_reached_i,
    input wire logic supply_below_uv_i,
    input wire logic supply_below_reset_i,
    input wire logic thermal_over_i,
    input wire logic switch_on_o,
    input wire logic [6:0] peak_current_cap_pct_o,
    input wire logic cap_increased_o,
    input wire logic auto_restart_state_o,
    input wire logic latched_off_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    logic [15:0] on_n;
    logic [15:0] off_n;
    logic short_hit;
    // cycles on and off; off count saturates so long waits never wrap
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            on_n <= 16'h0000;
            off_n <= 16'h0000;
            short_hit <= 1'b0;
        end else begin
            on_n <= switch_on_o ? on_n + 16'h0001 : 16'h0000;
            off_n <= switch_on_o ? 16'h0000 : (off_n == 16'hFFFF ? off_n : off_n + 16'h0001);
            if (switch_on_o && cap_reached_i) begin
                short_hit <= (on_n < 16'h0002);
            end
        end
    end
    AST_ON_CAUSE: assert property ($rose(switch_on_o) |-> $past(cycle_request_i))
        else $error("switch on without request");
    AST_CAP_OFF: assert property (switch_on_o && cap_reached_i |=> !switch_on_o)
        else $error("switch stayed on past cap");
    AST_UV_BLOCK: assert property ($rose(switch_on_o) |-> !$past(supply_below_uv_i))
        else $error("turn-on during supply undervoltage");
    AST_HOT_BLOCK: assert property ($rose(switch_on_o) |-> !$past(thermal_over_i))
        else $error("turn-on while over temperature");
    AST_PCT_RANGE: assert property (peak_current_cap_pct_o >= 7'h1E && peak_current_cap_pct_o <= 7'h64)
        else $error("limit outside floor and full");
    AST_LATCH_OFF: assert property (latched_off_o && $past(latched_off_o) |-> !switch_on_o)
        else $error("switching while latched off");
    AST_RESET_CLR: assert property (supply_below_reset_i [*2] |=> !latched_off_o && !auto_restart_state_o)
        else $error("supply reset did not clear fault");
    AST_CAP_HOLD: assert property (switch_on_o |-> $stable(cap_increased_o))
        else $error("cap selection moved while switching");
    AST_SHORT_OFF: assert property ($rose(switch_on_o) && short_hit |-> off_n >= 16'h024E)
        else $error("short detect off-time too brief");
    cover property ($rose(switch_on_o));
    cover property ($rose(auto_restart_state_o));
    cover property ($rose(latched_off_o));
endmodule

bind fpfc_core fpfc_core_sva fpfc_core_sva_i (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .cycle_request_i(cycle_request_i), .cap_reached_i(cap_reached_i), .supply_below_uv_i(supply_below_uv_i),
    .supply_below_reset_i(supply_below_reset_i), .thermal_over_i(thermal_over_i), .switch_on_o(switch_on_o),
    .peak_current_cap_pct_o(peak_current_cap_pct_o), .cap_increased_o(cap_increased_o),
    .auto_restart_state_o(auto_restart_state_o), .latched_off_o(latched_off_o));
`default_nettype wire

// File: tb/fpfc_secondary_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// secondary side and current sense
// ------------------------------
module fpfc_secondary_model (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic go_i,
    input wire logic [7:0] on_len_i,
    input wire logic switch_on_i,
    output logic cycle_request_o,
    output logic cap_reached_o
);
    logic [7:0] on_n;
    // one-cycle request per command; counts on-time for the sense ramp
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cycle_request_o <= 1'b0;
            on_n <= 8'h00;
        end else begin
            cycle_request_o <= go_i;
            on_n <= switch_on_i ? on_n + 8'h01 : 8'h00;
        end
    end
    // comparator only trips while conducting, so it drops with the switch
    assign cap_reached_o = switch_on_i && (on_n >= on_len_i);
endmodule
`default_nettype wire

// File: tb/fpfc_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module fpfc_core_test;
    logic clock_i = 1'b0, arst_n_i = 1'b0, go = 1'b0, uv = 1'b0, shunt = 1'b1, low = 1'b0, ocp = 1'b0;
    logic big = 1'b1, chg = 1'b0, hot = 1'b0, cool = 1'b0, tlatch = 1'b0, flatch = 1'b0, lu = 1'b0, lo = 1'b0;
    logic [7:0] len = 8'h14;
    logic [31:0] rnd = 32'h0187C729;
    logic req_w, cap_w, sw, inc, ar, lat, en;
    logic [6:0] pct;
    integer failures = 0, checks = 0, cyc = 0, i, t0;
    // ------------------------------
    // clock, design and far side
    // ------------------------------
    initial forever #25 clock_i = ~clock_i;
    always @(posedge clock_i) cyc <= cyc + 1;
    fpfc_core #(.AR_OFF_CYC(2000), .AR_OFF_SH_CYC(500), .SILENCE_CYC(3000), .OVL_CYC(1000), .LISTEN_CYC(1000),
        .SRS_LONG_CYC(2000), .RAMP_CYC(1000), .JIT_HALF_CYC(200)) fpfc_core_i (.clock_i(clock_i),
        .arst_n_i(arst_n_i), .cycle_request_i(req_w), .cap_reached_i(cap_w), .supply_below_uv_i(uv),
        .supply_at_shunt_i(shunt), .supply_below_reset_i(low), .supply_overcurrent_i(ocp),
        .supply_cap_large_i(big), .supply_charged_i(chg), .thermal_over_i(hot), .thermal_cooled_i(cool),
        .thermal_latch_mode_i(tlatch), .fault_latch_mode_i(flatch), .line_under_i(lu), .line_over_i(lo),
        .switch_on_o(sw), .peak_current_cap_pct_o(pct), .cap_increased_o(inc), .auto_restart_state_o(ar),
        .latched_off_o(lat), .switching_enabled_o(en));
    fpfc_secondary_model fpfc_secondary_model_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .go_i(go),
        .on_len_i(len), .switch_on_i(sw), .cycle_request_o(req_w), .cap_reached_o(cap_w));
    // ------------------------------
    // helpers
    // ------------------------------
    task automatic complete_run;
        if (failures == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input integer n);
        repeat (n) @(posedge clock_i);
    endtask
    // one request; caller says whether the switch must answer
    task automatic req(input logic [7:0] l, input logic exp);
        integer k;
        logic seen;
        seen = 1'b0;
        len <= l;
        go <= 1'b1;
        @(posedge clock_i);
        go <= 1'b0;
        for (k = 0; k < 6; k++) begin
            @(negedge clock_i);
            if (sw === 1'b1) seen = 1'b1;
        end
        for (k = 0; k < 300 && sw !== 1'b0; k++) @(negedge clock_i);
        if (sw !== 1'b0) begin
            failures = failures + 1;
            complete_run;
        end
        chk({7'h00, seen}, {7'h00, exp});
        @(posedge clock_i);
    endtask
    // reset, then charge the supply so the cap choice latches
    task automatic boot;
        arst_n_i <= 1'b0;
        chg <= 1'b0;
        tick(4);
        arst_n_i <= 1'b1;
        tick(2);
        chk({sw, pct}, 8'h64);
        chg <= 1'b1;
        tick(4);
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    initial begin
        boot;
        chk(inc, 8'h01);
        big <= 1'b0;
        tick(3);
        chk(inc, 8'h01);
        req(8'h14, 1'b1);
        tick(1500);
        req(8'h14, 1'b1);
        chk(pct, 8'h1E);
        req(8'h14, 1'b1);
        chk(pct >= 7'h5A, 8'h01);
        uv <= 1'b1;
        shunt <= 1'b0;
        tick(2);
        req(8'h14, 1'b0);
        uv <= 1'b0;
        tick(2);
        req(8'h14, 1'b0);
        shunt <= 1'b1;
        tick(2);
        req(8'h14, 1'b1);
        hot <= 1'b1;
        tick(2);
        req(8'h14, 1'b0);
        hot <= 1'b0;
        tick(2);
        req(8'h14, 1'b0);
        cool <= 1'b1;
        tick(2);
        req(8'h14, 1'b1);
        cool <= 1'b0;
        lo <= 1'b1;
        tick(2);
        req(8'h14, 1'b0);
        lo <= 1'b0;
        tick(2);
        req(8'h14, 1'b1);
        req(8'h01, 1'b1);
        tick(300);
        req(8'h14, 1'b0);
        tick(320);
        req(8'h01, 1'b1);
        tick(1000);
        req(8'h14, 1'b0);
        tick(1100);
        req(8'h14, 1'b1);
        req(8'h07, 1'b1);
        req(8'h07, 1'b1);
        req(8'h14, 1'b0);
        tick(520);
        req(8'h14, 1'b1);
        flatch <= 1'b1;
        ocp <= 1'b1;
        tick(3);
        ocp <= 1'b0;
        tick(3);
        chk(lat, 8'h01);
        req(8'h14, 1'b0);
        low <= 1'b1;
        tick(3);
        low <= 1'b0;
        flatch <= 1'b0;
        tick(3);
        chk(lat, 8'h00);
        tlatch <= 1'b1;
        hot <= 1'b1;
        tick(2);
        hot <= 1'b0;
        cool <= 1'b1;
        tick(3);
        req(8'h14, 1'b0);
        lu <= 1'b1;
        tick(3);
        lu <= 1'b0;
        tick(3);
        chk(lat, 8'h00);
        req(8'h14, 1'b1);
        tlatch <= 1'b0;
        cool <= 1'b0;
        boot;
        t0 = cyc;
        for (i = 0; i < 40 && ar !== 1'b1; i++) begin
            rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
            // random on-time stays past the early window and ends before the next request
            len <= 8'h0A + {4'h0, rnd[8:5]};
            go <= 1'b1;
            tick(1);
            go <= 1'b0;
            tick(40 + rnd[4:0]);
        end
        chk(ar, 8'h01);
        chk(cyc - t0 >= 1000, 8'h01);
        req(8'h14, 1'b0);
        lu <= 1'b1;
        tick(3);
        chk(ar, 8'h00);
        lu <= 1'b0;
        boot;
        tick(3100);
        chk(ar, 8'h01);
        tick(400);
        chk(ar, 8'h01);
        // short off plus listen timeout have passed: back to running
        tick(1150);
        chk(ar, 8'h00);
        // second silence fault uses the full off-time, so still restarting here
        tick(5045);
        chk(ar, 8'h01);
        complete_run;
    end
endmodule
`default_nettype wire
